// ---- logic/fbbx_exec.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fbbx_params.svh"

module fbbx_exec
   import fbbx_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire fbbx_apb_req_s apbReq,
   output var fbbx_apb_rsp_s apbRsp
);

   fbbx_state_e state;
   logic [23:0] ir;
   logic [23:0] pc;
   logic flagCarry;
   logic flagZero;
   logic accbSaturationFlag;
   logic unsupported;
   logic [3:0] wSel;
   logic [11:0] mAddr;
   logic [15:0] workReg [0:15];
   logic [15:0] dataMem [0:4095];

   // apb decode
   logic access;
   logic commit;
   logic mapped;
   logic [31:0] readData;
   logic wrInstr;
   logic wrPc;
   logic wrStatus;
   logic wrWsel;
   logic wrWdata;
   logic wrMaddr;
   logic wrMdata;

   // execution decode
   logic [7:0] opcode;
   logic isBranch;
   logic takeBranch;
   logic isFileOp;
   logic isWsOp;
   logic legalOp;
   logic byteMode;
   logic directMode;
   logic pointerMode;
   logic [2:0] addrMode;
   logic [3:0] sourceWorkReg;
   logic [15:0] sourceVal;
   logic [15:0] step;
   logic [15:0] newPointer;
   logic [15:0] effAddr;
   logic [11:0] memIdx;
   logic [3:0] bitNumberField;
   logic [3:0] bitIdx;
   logic [15:0] operand;
   logic [15:0] aluResult;
   logic writeVal;
   fbbx_bitop_e bitOp;
   logic [23:0] pcInc;
   logic [15:0] signedBranchOffset;
   logic [23:0] branchTarget;
   logic execOp;

   assign access = apbReq.psel & apbReq.penable;
   assign commit = access & apbRsp.pready & apbReq.pwrite & mapped;
   assign wrInstr = commit && apbReq.paddr == `FBBX_OFF_INSTR;
   assign wrPc = commit && apbReq.paddr == `FBBX_OFF_PC;
   assign wrStatus = commit && apbReq.paddr == `FBBX_OFF_STATUS;
   assign wrWsel = commit && apbReq.paddr == `FBBX_OFF_WSEL;
   assign wrWdata = commit && apbReq.paddr == `FBBX_OFF_WDATA;
   assign wrMaddr = commit && apbReq.paddr == `FBBX_OFF_MADDR;
   assign wrMdata = commit && apbReq.paddr == `FBBX_OFF_MDATA;

   always_comb begin
      mapped = 1'b1;
      readData = 32'h00000000;
      unique case (apbReq.paddr)
         `FBBX_OFF_INSTR: readData = {8'h00, ir};
         `FBBX_OFF_PC: readData = {8'h00, pc};
         `FBBX_OFF_STATUS: begin
            readData[`FBBX_ST_CARRY] = flagCarry;
            readData[`FBBX_ST_ZERO] = flagZero;
            readData[`FBBX_ST_ACCB_SAT] = accbSaturationFlag;
            readData[`FBBX_ST_BUSY] = (state != FBBX_IDLE);
            readData[`FBBX_ST_UNSUP] = unsupported;
         end
         `FBBX_OFF_WSEL: readData = {28'h0000000, wSel};
         `FBBX_OFF_WDATA: readData = {16'h0000, workReg[wSel]};
         `FBBX_OFF_MADDR: readData = {19'h00000, mAddr, 1'b0};
         `FBBX_OFF_MDATA: readData = {16'h0000, dataMem[mAddr]};
         default: mapped = 1'b0;
      endcase
   end

   // one wait state; no answer while an instruction is in flight
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         apbRsp <= '0;
      end else if (access && !apbRsp.pready && state == FBBX_IDLE) begin
         apbRsp.pready <= 1'b1;
         apbRsp.prdata <= readData;
         apbRsp.pslverr <= ~mapped;
      end else begin
         apbRsp.pready <= 1'b0;
         apbRsp.pslverr <= 1'b0;
      end
   end

   // decode of the issued word; fields come from ir, except the bit-write bit number, taken from the working register named by ir[14:11]
   always_comb begin
      opcode = ir[23:16];
      isBranch = opcode == `FBBX_OP_BRA_ACCB_SAT || opcode == `FBBX_OP_BRA_ZERO;
      takeBranch = (opcode == `FBBX_OP_BRA_ACCB_SAT && accbSaturationFlag) ||
                   (opcode == `FBBX_OP_BRA_ZERO && flagZero);
      isFileOp = opcode == `FBBX_OP_SET_FILE || opcode == `FBBX_OP_TOGGLE_FILE;
      isWsOp = opcode == `FBBX_OP_SET_WREG || opcode == `FBBX_OP_TOGGLE_WREG ||
               opcode == `FBBX_OP_WRITE_WREG;
      addrMode = ir[6:4];
      sourceWorkReg = ir[3:0];
      sourceVal = workReg[sourceWorkReg];
      byteMode = isWsOp && opcode != `FBBX_OP_WRITE_WREG && ir[10]; // bit-write is word-only
      directMode = addrMode == `FBBX_MODE_DIRECT;
      pointerMode = addrMode >= `FBBX_MODE_POST_INC && addrMode <= `FBBX_MODE_PRE_DEC;
      legalOp = isBranch || isFileOp || (isWsOp && addrMode <= `FBBX_MODE_PRE_DEC);
      step = byteMode ? `FBBX_STEP_BYTE : `FBBX_STEP_WORD;
      newPointer = sourceVal;
      effAddr = sourceVal;
      unique case (addrMode)
         `FBBX_MODE_POST_INC: newPointer = sourceVal + step;
         `FBBX_MODE_POST_DEC: newPointer = sourceVal - step;
         `FBBX_MODE_PRE_INC: begin
            newPointer = sourceVal + step;
            effAddr = newPointer;
         end
         `FBBX_MODE_PRE_DEC: begin
            newPointer = sourceVal - step;
            effAddr = newPointer;
         end
         default: begin
            newPointer = sourceVal;
            effAddr = sourceVal;
         end
      endcase
      // word-mode pointers are taken as even; bit 0 only picks the byte
      if (isFileOp) begin
         memIdx = ir[12:1];
         bitNumberField = {ir[15:13], ir[0]};
      end else begin
         memIdx = effAddr[12:1];
         bitNumberField = ir[15:12];
      end
      if (opcode == `FBBX_OP_WRITE_WREG) begin
         bitIdx = workReg[ir[14:11]][3:0];
      end else if (byteMode) begin
         // byte bit number taken as 0..7
         bitIdx = {(~directMode) & effAddr[0], bitNumberField[2:0]};
      end else begin
         bitIdx = bitNumberField;
      end
      operand = (isWsOp && directMode) ? sourceVal : dataMem[memIdx];
      writeVal = ir[15] ? ~flagZero : flagCarry;
      if (opcode == `FBBX_OP_SET_FILE || opcode == `FBBX_OP_SET_WREG) begin
         bitOp = FBBX_BIT_SET;
      end else if (opcode == `FBBX_OP_WRITE_WREG) begin
         bitOp = FBBX_BIT_WRITE;
      end else begin
         bitOp = FBBX_BIT_TOGGLE;
      end
      pcInc = pc + `FBBX_PC_STEP;
      signedBranchOffset = ir[15:0];
      branchTarget = pcInc + {{7{signedBranchOffset[15]}}, signedBranchOffset, 1'b0};
      execOp = state == FBBX_EXEC && legalOp && !isBranch;
   end

   // one shared datapath for set, toggle and write
   fbbx_bit_alu bitAlu (
      .op(bitOp),
      .operand(operand),
      .bitIdx(bitIdx),
      .writeVal(writeVal),
      .result(aluResult)
   );

   // idle, then one exec cycle, then a nop slot only for a taken branch
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= FBBX_IDLE;
      end else begin
         unique case (state)
            FBBX_IDLE: if (wrInstr) begin
               state <= FBBX_EXEC;
            end
            FBBX_EXEC: state <= takeBranch ? FBBX_NOPSLOT : FBBX_IDLE;
            FBBX_NOPSLOT: state <= FBBX_IDLE;
            default: state <= FBBX_IDLE;
         endcase
      end
   end

   // a taken branch replaces the issued branch word in ir with the nop word
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ir <= `FBBX_IR_RST;
      end else if (wrInstr) begin
         ir <= apbReq.pwdata[23:0];
      end else if (state == FBBX_EXEC && takeBranch) begin
         ir <= `FBBX_NOP_WORD;
      end
   end

   // software moves the counter only while the core is idle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pc <= `FBBX_PC_RST;
      end else if (wrPc) begin
         pc <= {apbReq.pwdata[23:1], 1'b0};
      end else if (state == FBBX_EXEC) begin
         pc <= takeBranch ? branchTarget : pcInc;
      end
   end

   // flags change only by software; execution never touches them
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flagCarry <= 1'b0;
         flagZero <= 1'b0;
         accbSaturationFlag <= 1'b0;
      end else if (wrStatus) begin
         flagCarry <= apbReq.pwdata[`FBBX_ST_CARRY];
         flagZero <= apbReq.pwdata[`FBBX_ST_ZERO];
         accbSaturationFlag <= apbReq.pwdata[`FBBX_ST_ACCB_SAT];
      end
   end

   // sticky, write one to clear; a new event wins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         unsupported <= 1'b0;
      end else if (state == FBBX_EXEC && !legalOp) begin
         unsupported <= 1'b1;
      end else if (wrStatus && apbReq.pwdata[`FBBX_ST_UNSUP]) begin
         unsupported <= 1'b0;
      end
   end

   // apb window onto one working register and one memory word
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wSel <= 4'h0;
         mAddr <= 12'h000;
      end else begin
         if (wrWsel) begin
            wSel <= apbReq.pwdata[3:0];
         end
         if (wrMaddr) begin
            mAddr <= apbReq.pwdata[12:1];
         end
      end
   end

   // no reset: contents are loaded over apb before use
   // apb loads cannot meet execution since answers wait for idle
   always_ff @(posedge clk) begin
      if (wrWdata) begin
         workReg[wSel] <= apbReq.pwdata[15:0];
      end else if (execOp && isWsOp && directMode) begin
         workReg[sourceWorkReg] <= aluResult;
      end else if (execOp && isWsOp && pointerMode) begin
         workReg[sourceWorkReg] <= newPointer;
      end
   end

   // word array; byte forms reach a half through the bit index
   always_ff @(posedge clk) begin
      if (wrMdata) begin
         dataMem[mAddr] <= apbReq.pwdata[15:0];
      end else if (execOp && !(isWsOp && directMode)) begin
         dataMem[memIdx] <= aluResult;
      end
   end

endmodule : fbbx_exec

`default_nettype wire

// ---- shared/fbbx_params.svh ----
`ifndef FBBX_PARAMS_SVH
`define FBBX_PARAMS_SVH

// register byte offsets
`define FBBX_OFF_INSTR 12'h000
`define FBBX_OFF_PC 12'h004
`define FBBX_OFF_STATUS 12'h008
`define FBBX_OFF_WSEL 12'h00C
`define FBBX_OFF_WDATA 12'h010
`define FBBX_OFF_MADDR 12'h014
`define FBBX_OFF_MDATA 12'h018

// status_word field positions
`define FBBX_ST_CARRY 0
`define FBBX_ST_ZERO 1
`define FBBX_ST_ACCB_SAT 2
`define FBBX_ST_BUSY 8
`define FBBX_ST_UNSUP 9

// reset and flush values
`define FBBX_PC_RST 24'h000000
`define FBBX_IR_RST 24'h000000
`define FBBX_NOP_WORD 24'h000000

// upper-byte opcodes
`define FBBX_OP_BRA_ACCB_SAT 8'h0F
`define FBBX_OP_BRA_ZERO 8'h32
`define FBBX_OP_SET_FILE 8'hA8
`define FBBX_OP_SET_WREG 8'hA0
`define FBBX_OP_WRITE_WREG 8'hAD
`define FBBX_OP_TOGGLE_FILE 8'hAA
`define FBBX_OP_TOGGLE_WREG 8'hA2

// source addressing modes
`define FBBX_MODE_DIRECT 3'h0
`define FBBX_MODE_IND 3'h1
`define FBBX_MODE_POST_INC 3'h2
`define FBBX_MODE_POST_DEC 3'h3
`define FBBX_MODE_PRE_INC 3'h4
`define FBBX_MODE_PRE_DEC 3'h5

// address steps
`define FBBX_STEP_WORD 16'h0002
`define FBBX_STEP_BYTE 16'h0001
`define FBBX_PC_STEP 24'h000002

`endif

// ---- shared/fbbx_pkg.sv ----
`default_nettype none
package fbbx_pkg;

   typedef enum logic [1:0] {
      FBBX_IDLE = 2'b00,
      FBBX_EXEC = 2'b01,
      FBBX_NOPSLOT = 2'b10
   } fbbx_state_e;

   typedef enum logic [1:0] {
      FBBX_BIT_SET = 2'b00,
      FBBX_BIT_TOGGLE = 2'b01,
      FBBX_BIT_WRITE = 2'b10
   } fbbx_bitop_e;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } fbbx_apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } fbbx_apb_rsp_s;

endpackage : fbbx_pkg

`default_nettype wire

// ---- logic/fbbx_bit_alu.sv ----
`timescale 1ns/1ps
`default_nettype none

module fbbx_bit_alu
   import fbbx_pkg::*;
(
   input wire fbbx_bitop_e op,
   input wire logic [15:0] operand,
   input wire logic [3:0] bitIdx,
   input wire logic writeVal,
   output logic [15:0] result
);

   logic [15:0] mask;

   always_comb begin
      mask = 16'h0001 << bitIdx;
      unique case (op)
         FBBX_BIT_SET: result = operand | mask;
         FBBX_BIT_TOGGLE: result = operand ^ mask;
         FBBX_BIT_WRITE: result = writeVal ? (operand | mask) : (operand & ~mask);
         default: result = operand;
      endcase
   end

endmodule : fbbx_bit_alu

`default_nettype wire

// ---- verification/fbbx_exec_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module fbbx_exec_checker
   import fbbx_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire fbbx_apb_req_s apbReq,
   input wire fbbx_apb_rsp_s apbRsp
);
   logic acc, rdy, done;
   logic [11:0] a;
   logic [2:0] flags;
   assign acc = apbReq.psel && apbReq.penable;
   assign rdy = apbRsp.pready;
   assign done = acc && rdy;
   assign a = apbReq.paddr;
   // flags as last written by software
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flags <= 3'h0;
      end else if (done && apbReq.pwrite && a == 12'h008) begin
         flags <= apbReq.pwdata[2:0];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_acc;
      rdy || apbRsp.pslverr |-> acc;
   endproperty
   a_acc: assert property (p_acc) else $error("answer outside access");
   property p_pulse;
      rdy |=> !rdy;
   endproperty
   a_pulse: assert property (p_pulse) else $error("pready too long");
   property p_map;
      done |-> apbRsp.pslverr == (a[1:0] != 2'h0 || a > 12'h018);
   endproperty
   a_map: assert property (p_map) else $error("bad pslverr");
   property p_zero;
      done && apbRsp.pslverr && !apbReq.pwrite |-> apbRsp.prdata == 32'h0;
   endproperty
   a_zero: assert property (p_zero) else $error("refused read not zero");
   property p_hold;
      !rdy ##1 !rdy |-> $stable(apbRsp.prdata);
   endproperty
   a_hold: assert property (p_hold) else $error("prdata moved");
   property p_flags;
      done && !apbReq.pwrite && a == 12'h008 |-> apbRsp.prdata[2:0] == flags;
   endproperty
   a_flags: assert property (p_flags) else $error("flags changed");
   property p_wait;
      $rose(acc) |-> ##[1:3] rdy;
   endproperty
   a_wait: assert property (p_wait) else $error("answer late");
   property p_rst;
      disable iff (1'b0) rst |=> !rdy && apbRsp.prdata == 32'h0;
   endproperty
   a_rst: assert property (p_rst) else $error("busy in reset");
endmodule : fbbx_exec_checker
bind fbbx_exec fbbx_exec_checker u_chk (.clk(clk), .rst(rst), .apbReq(apbReq),
   .apbRsp(apbRsp));
`default_nettype wire

// ---- verification/fbbx_apb_master.sv ----
`timescale 1ns/1ps
`default_nettype none
module fbbx_apb_master
   import fbbx_pkg::*;
(
   input wire logic clk,
   output var fbbx_apb_req_s apbReq,
   input wire fbbx_apb_rsp_s apbRsp
);
   initial apbReq = '0;
   // entered right after a rising edge; leaves one idle cycle
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
         output logic [31:0] q, output logic e);
      apbReq <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk);
      apbReq.penable <= 1'b1;
      do @(posedge clk); while (apbRsp.pready !== 1'b1);
      q = apbRsp.prdata;
      e = apbRsp.pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
      @(posedge clk);
   endtask : xfer
endmodule : fbbx_apb_master
`default_nettype wire

// ---- verification/fbbx_exec_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module fbbx_exec_tb_top
   import fbbx_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   fbbx_apb_req_s apbReq;
   fbbx_apb_rsp_s apbRsp;
   int n_mismatch = 0;
   int comparisons = 0;
   logic [31:0] seed = 32'h04E66C02;
   logic [31:0] r, rd;
   logic err, tk, byt, wv;
   logic [7:0] op;
   logic [3:0] b, s, wb;
   logic [2:0] md, fl;
   logic [15:0] v, m, st, ptr, ea, np, ex;
   logic [23:0] pc;
   always #12.5 clk = ~clk;
   fbbx_exec DUT (.clk(clk), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp));
   fbbx_apb_master mst (.clk(clk), .apbReq(apbReq), .apbRsp(apbRsp));
   function automatic void nxt();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      r = seed;
   endfunction : nxt
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      mst.xfer(1'b1, a, d, rd, err);
   endtask : wr
   task automatic chk(input logic [11:0] a, input logic [31:0] x);
      mst.xfer(1'b0, a, 32'h0, rd, err);
      comparisons++;
      if (rd !== x || err !== (a > 12'h018)) begin
         n_mismatch++;
         $display("Error at %0t: read %h gave %h, expected %h", $time, a, rd, x);
      end
   endtask : chk
   task automatic test_done();
      $display("mismatches %0d, comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : test_done
   initial begin
      #400000;
      n_mismatch++;
      test_done();
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(12'h004, 32'h0);
      chk(12'h01C, 32'h0);
      for (int i = 0; i < 24; i++) begin
         nxt();
         pc = r[23:0] & 24'hFFFFFE;
         v = (i == 0) ? 16'h8000 : (i == 1) ? 16'h7FFF : r[15:0];
         fl = r[26:24];
         op = r[27] ? 8'h0F : 8'h32;
         tk = r[27] ? fl[2] : fl[1];
         wr(12'h008, {29'h0, fl});
         wr(12'h004, {8'h0, pc});
         wr(12'h000, {8'h0, op, v});
         chk(12'h000, tk ? 32'h0 : {8'h0, op, v});
         chk(12'h004, {8'h0, pc + 24'h2 + (tk ? {{7{v[15]}}, v, 1'b0} : 24'h0)});
      end
      for (int i = 0; i < 16; i++) begin
         nxt();
         b = i[3:0];
         ea = (i == 15) ? 16'h1FFE : {3'h0, r[12:1], 1'b0};
         m = 16'h1 << b;
         wr(12'h014, {16'h0, ea});
         wr(12'h018, {16'h0, r[31:16]});
         wr(12'h000, {8'h0, r[20] ? 8'hAA : 8'hA8, b[3:1], ea[12:1], b[0]});
         chk(12'h018, {16'h0, r[20] ? r[31:16] ^ m : r[31:16] | m});
      end
      for (int i = 0; i < 36; i++) begin
         nxt();
         op = (i % 3 == 0) ? 8'hA0 : (i % 3 == 1) ? 8'hA2 : 8'hAD;
         md = 3'((i / 3) % 6);
         byt = i >= 18 && op != 8'hAD;
         s = r[3:0];
         wb = s + 4'h1;
         b = byt ? {1'b0, r[6:4]} : r[7:4];
         ptr = {4'h0, r[19:9], byt & r[8]};
         fl = r[22:20];
         tk = r[23];
         wv = tk ? ~fl[1] : fl[0];
         st = byt ? 16'h1 : 16'h2;
         ea = (md == 3'h4) ? ptr + st : (md == 3'h5) ? ptr - st : ptr;
         np = (md == 3'h2 || md == 3'h4) ? ptr + st : (md == 3'h3 || md == 3'h5) ? ptr - st : ptr;
         m = 16'h1 << (b + ((byt && md != 3'h0 && ea[0]) ? 4'h8 : 4'h0));
         nxt();
         v = r[15:0];
         ex = (op == 8'hA2) ? v ^ m : (op == 8'hA0 || wv) ? v | m : v & ~m;
         wr(12'h008, {29'h0, fl});
         wr(12'h00C, {28'h0, wb});
         wr(12'h010, {16'h0, r[31:20], b});
         wr(12'h00C, {28'h0, s});
         wr(12'h010, {16'h0, md == 3'h0 ? v : ptr});
         wr(12'h014, {16'h0, ea});
         wr(12'h018, {16'h0, v});
         wr(12'h000, op == 8'hAD ? {8'h0, op, tk, wb, 4'h0, md, s}
            : {8'h0, op, b, 1'b0, byt, 3'h0, md, s});
         chk(12'h010, {16'h0, md == 3'h0 ? ex : np});
         if (md != 3'h0) chk(12'h018, {16'h0, ex});
         chk(12'h008, {29'h0, fl});
      end
      // unsupported mode and unknown opcode: no data written, pc still advances, sticky flag set
      wr(12'h000, {8'h0, 8'hA0, 16'h0060});
      chk(12'h008, {22'h0, 1'b1, 6'h0, fl});
      wr(12'h008, 32'h00000200);
      chk(12'h008, 32'h00000000);
      wr(12'h000, 32'h00550000);
      chk(12'h008, 32'h00000200);
      wr(12'h008, 32'h00000200);
      chk(12'h008, 32'h00000000);
      test_done();
   end
endmodule : fbbx_exec_tb_top
`default_nettype wire
